// *** core/cfsg_core.sv ***
// Clock fan-out buffer: source select, runt-free halt gate, output enable.
// Assumes all pins are synchronous to ref_clk, which oversamples sources.
`include "cfsg_map.svh"

module cfsg_core
	import cfsg_pkg::*;
#(
	parameter int NUM_OUT = `CFSG_NUM_OUT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire cfsg_src_t src_in,
	input wire cfsg_ctrl_t ctrl,
	output logic [NUM_OUT-1:0] fanout_clock_outputs,
	output logic [NUM_OUT-1:0] fanout_clock_oe
);

	// Refuse widths that the fan-out cannot serve
	if (NUM_OUT < 1) begin : g_bad_num_out
		$error("cfsg_core: NUM_OUT must be at least 1");
	end

	logic src_reg;
	logic src_next;
	logic src_fall;
	cfsg_gate_t gate_reg;
	cfsg_gate_t gate_next;
	logic [NUM_OUT-1:0] clk_reg;
	logic [NUM_OUT-1:0] clk_next;
	logic [NUM_OUT-1:0] oe_reg;
	logic [NUM_OUT-1:0] oe_next;

	// Selected source level as seen by ref_clk
	always_comb begin
		src_next = src_reg;
		unique case (ctrl.sel)
			`CFSG_SEL_ALT: begin
				src_next = src_in.alt_single_ended_clock;
			end
			`CFSG_SEL_DIFF: begin
				// Equal pair levels carry no edge; hold the last level
				if (src_in.diff_p != src_in.diff_n) begin
					src_next = src_in.diff_p;
				end
			end
		endcase
		src_fall = src_reg && !src_next;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			src_reg <= `CFSG_RST_SRC;
		end else begin
			src_reg <= src_next;
		end
	end

	// Halt gate; it moves only at a falling edge, so the output is low then
	always_comb begin
		gate_next = gate_reg;
		if (src_fall) begin
			gate_next = ctrl.halt_n ? CFSG_RUNNING : CFSG_STOPPED;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gate_reg <= cfsg_gate_t'(`CFSG_RST_RUN);
		end else begin
			gate_reg <= gate_next;
		end
	end

	// Output copies and drive enables, registered so pins come from flops
	always_comb begin
		clk_next = '0;
		if (gate_next == CFSG_RUNNING) begin
			clk_next = {NUM_OUT{src_next}};
		end
		oe_next = {NUM_OUT{ctrl.drive_en}};
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clk_reg <= '0;
			oe_reg <= {NUM_OUT{`CFSG_RST_DRIVE}};
		end else begin
			clk_reg <= clk_next;
			oe_reg <= oe_next;
		end
	end

	assign fanout_clock_outputs = clk_reg;
	assign fanout_clock_oe = oe_reg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	property p_copy;
		(gate_reg == CFSG_RUNNING) |-> (clk_reg == {NUM_OUT{src_reg}});
	endproperty
	a_copy: assert property (p_copy) else $error("output not a copy");

	property p_sel_alt;
		ctrl.sel |=> (src_reg == $past(src_in.alt_single_ended_clock));
	endproperty
	a_sel_alt: assert property (p_sel_alt) else $error("alt not taken");

	property p_sel_diff;
		(!ctrl.sel && (src_in.diff_p != src_in.diff_n))
			|=> (src_reg == $past(src_in.diff_p));
	endproperty
	a_sel_diff: assert property (p_sel_diff) else $error("pair not taken");

	property p_drive;
		ctrl.drive_en |=> (&oe_reg);
	endproperty
	a_drive: assert property (p_drive) else $error("outputs not driven");

	property p_float;
		(!ctrl.drive_en && !ctrl.halt_n) |=> (oe_reg == '0);
	endproperty
	a_float: assert property (p_float) else $error("outputs not floated");

	property p_stopped_low;
		(gate_reg == CFSG_STOPPED) |-> (clk_reg == '0);
	endproperty
	a_stopped_low: assert property (p_stopped_low) else $error("stop not low");

	property p_gate_at_fall;
		$changed(gate_reg) |-> ($past(src_reg) && !src_reg);
	endproperty
	a_gate_at_fall: assert property (p_gate_at_fall) else $error("gate off edge");

	property p_no_runt;
		$changed(gate_reg) |-> !clk_reg[0];
	endproperty
	a_no_runt: assert property (p_no_runt) else $error("gate change high");

	property p_halt_now;
		(src_reg && !src_next && !ctrl.halt_n)
			|=> (gate_reg == CFSG_STOPPED) ##0 (clk_reg == '0);
	endproperty
	a_halt_now: assert property (p_halt_now) else $error("halt late");

	property p_release;
		(src_reg && !src_next && ctrl.halt_n) ##1 src_next
			|=> (clk_reg == {NUM_OUT{1'b1}});
	endproperty
	a_release: assert property (p_release) else $error("release lost");

	// Source, pair, output and halt gate checks
	property p_pair_hold;
		(!ctrl.sel && (src_in.diff_p == src_in.diff_n))
			|=> $stable(src_reg);
	endproperty
	a_pair_hold: assert property (p_pair_hold) else $error("pair moved");

	property p_alt_out;
		(ctrl.sel && (gate_next == CFSG_RUNNING))
			|=> (clk_reg[0] == $past(src_in.alt_single_ended_clock));
	endproperty
	a_alt_out: assert property (p_alt_out) else $error("alt not out");

	property p_same;
		clk_reg == {NUM_OUT{clk_reg[0]}};
	endproperty
	a_same: assert property (p_same) else $error("outputs differ");

	property p_halt_idle;
		!(src_reg && !src_next) |=> $stable(gate_reg);
	endproperty
	a_halt_idle: assert property (p_halt_idle) else $error("gate moved");

	property p_stop_hold;
		((gate_reg == CFSG_STOPPED) && !src_fall) |=> (clk_reg == '0);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("halt leaked");

	// Output edges follow source edges, so no high phase is cut short
	property p_rise_src;
		$rose(clk_reg[0]) |-> $rose(src_reg);
	endproperty
	a_rise_src: assert property (p_rise_src) else $error("rise off edge");

	property p_fall_src;
		$fell(clk_reg[0]) |-> $fell(src_reg);
	endproperty
	a_fall_src: assert property (p_fall_src) else $error("fall off edge");

	// Drive enable paths
	property p_float_any;
		!ctrl.drive_en |=> (oe_reg == '0);
	endproperty
	a_float_any: assert property (p_float_any) else $error("not floated");

	property p_oe_same;
		oe_reg == {NUM_OUT{oe_reg[0]}};
	endproperty
	a_oe_same: assert property (p_oe_same) else $error("enables differ");

	property p_oe_indep;
		$changed(ctrl.halt_n) |=> (oe_reg == {NUM_OUT{$past(ctrl.drive_en)}});
	endproperty
	a_oe_indep: assert property (p_oe_indep) else $error("halt moved oe");

	c_stop: cover property ($fell(gate_reg));
	c_restart: cover property ($rose(gate_reg) ##[1:20] clk_reg[0]);
	c_switch: cover property ($changed(ctrl.sel) ##1 clk_reg[0]);
	c_float: cover property ($fell(oe_reg[0]));
	c_hold: cover property (!ctrl.sel && (src_in.diff_p == src_in.diff_n));

endmodule : cfsg_core

// *** core/cfsg_map.svh ***
// Constants for the clock fan-out select and gate block.
// Included by the package and the core; definitions only.
`ifndef CFSG_MAP_SVH
`define CFSG_MAP_SVH

// Number of fan-out outputs
`define CFSG_NUM_OUT 12
// Source select codes
`define CFSG_SEL_DIFF 1'h0
`define CFSG_SEL_ALT 1'h1
// Reset values: run and drive mirror the pulled-up control defaults; the source level resets low
`define CFSG_RST_RUN 1'h1
`define CFSG_RST_DRIVE 1'h1
`define CFSG_RST_SRC 1'h0

`endif

// *** core/cfsg_pkg.sv ***
// Types shared by the clock fan-out select and gate block.
// Assumes cfsg_map.svh is on the include path.
`include "cfsg_map.svh"

package cfsg_pkg;

	// Control pins, all sampled on ref_clk
	typedef struct packed {
		logic sel;
		logic drive_en;
		logic halt_n;
	} cfsg_ctrl_t;

	// Clock source pins
	typedef struct packed {
		logic diff_p;
		logic diff_n;
		logic alt_single_ended_clock;
	} cfsg_src_t;

	typedef enum logic {
		CFSG_STOPPED = 1'b0,
		CFSG_RUNNING = 1'b1
	} cfsg_gate_t;

endpackage : cfsg_pkg

// *** dv/cfsg_src_model.sv ***
// Board clock source: a pair clock and a slower single-ended clock.
// Assumes the sources move just after ref_clk rising edges.
module cfsg_src_model
	import cfsg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic pair_bad,
	output cfsg_src_t src
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_reg = 2'h0;
	always @(posedge ref_clk) begin
		cnt_reg <= cnt_reg + 2'h1;
	end
	// A faulty pair shows both pins at one level and carries no edge
	assign src = '{cnt_reg[0],
		pair_bad ? cnt_reg[0] : ~cnt_reg[0],
		cnt_reg[1]};
endmodule : cfsg_src_model

// *** dv/tb_top.sv ***
// Testbench for the fan-out core, fed by the board source model.
// Assumes ref_clk oversamples both source clocks.
module tb_top
	import cfsg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	cfsg_src_t src;
	cfsg_ctrl_t ctrl = '{1'b1, 1'b1, 1'b1};
	logic [11:0] q, oe, exp_q, exp_oe;
	logic lvl, gate, nl, drv;
	logic pair_bad = 1'b0;
	int error_cnt = 0;
	int n_tests = 0;
	always #20 ref_clk = ~ref_clk;
	cfsg_src_model i_src (.ref_clk(ref_clk), .pair_bad(pair_bad),
		.src(src));
	cfsg_core i_dut (.ref_clk(ref_clk), .rst(rst), .src_in(src),
		.ctrl(ctrl), .fanout_clock_outputs(q), .fanout_clock_oe(oe));
	// Expected outputs from the function table
	always_comb begin
		nl = lvl;
		if (ctrl.sel) begin
			nl = src.alt_single_ended_clock;
		end else if (src.diff_p != src.diff_n) begin
			nl = src.diff_p;
		end
	end
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lvl <= 1'b0;
			gate <= 1'b1;
			drv <= 1'b1;
		end else begin
			lvl <= nl;
			if (lvl && !nl) gate <= ctrl.halt_n;
			drv <= ctrl.drive_en;
		end
	end
	assign exp_q = {12{gate & lvl}};
	assign exp_oe = {12{drv}};
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic run(input int n);
		repeat (n) begin
			@(negedge ref_clk);
			chk(q, exp_q);
			chk(oe, exp_oe);
		end
	endtask : run
	task automatic halts();
		for (int i = 0; i < 9; i++) begin
			@(posedge ref_clk) ctrl.halt_n <= i[0];
			run(1 + i % 3);
		end
	endtask : halts
	task automatic halt_long();
		logic hi;
		@(posedge ref_clk) ctrl.halt_n <= 1'b0;
		run(8);
		repeat (8) begin
			@(negedge ref_clk);
			chk(q, 12'h000);
		end
		@(posedge ref_clk) ctrl.halt_n <= 1'b1;
		hi = 1'b0;
		repeat (8) begin
			@(negedge ref_clk);
			chk(q, exp_q);
			hi = hi | q[0];
		end
		chk({11'h000, hi}, 12'h001);
	endtask : halt_long
	task automatic t_alt();
		@(posedge ref_clk) ctrl <= '{1'b1, 1'b1, 1'b1};
		run(6);
		halts();
		halt_long();
		$display("t_alt done");
	endtask : t_alt
	task automatic t_diff();
		@(posedge ref_clk) ctrl <= '{1'b0, 1'b1, 1'b1};
		run(6);
		halts();
		halt_long();
		$display("t_diff done");
	endtask : t_diff
	task automatic t_oe();
		@(posedge ref_clk) ctrl <= '{1'b1, 1'b0, 1'b0};
		run(4);
		@(posedge ref_clk) ctrl.halt_n <= 1'b1;
		run(4);
		@(posedge ref_clk) ctrl.drive_en <= 1'b1;
		run(4);
		$display("t_oe done");
	endtask : t_oe
	task automatic t_pair();
		logic [11:0] held;
		@(posedge ref_clk) ctrl <= '{1'b0, 1'b1, 1'b1};
		run(4);
		@(posedge ref_clk) pair_bad <= 1'b1;
		run(1);
		held = exp_q;
		run(6);
		chk(q, held);
		@(posedge ref_clk) pair_bad <= 1'b0;
		run(4);
		$display("t_pair done");
	endtask : t_pair
	task automatic t_reset();
		@(posedge ref_clk) ctrl.drive_en <= 1'b0;
		run(3);
		@(posedge ref_clk) rst <= 1'b1;
		repeat (3) begin
			@(negedge ref_clk);
			chk(q, 12'h000);
			chk(oe, 12'hfff);
		end
		@(posedge ref_clk) rst <= 1'b0;
		run(4);
		$display("t_reset done");
	endtask : t_reset
	task automatic stop_test();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	initial begin
		#(40 * 2000);
		error_cnt++;
		stop_test();
	end
	initial begin
		run(20);
		@(posedge ref_clk) rst <= 1'b0;
		t_alt();
		t_diff();
		t_pair();
		t_oe();
		t_reset();
		stop_test();
	end
endmodule : tb_top
